/* dv/csd_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module csd_properties
   import spec_data_pkg::*;
#(
   parameter logic [CAP_W-1:0] CAPACITY_SIZE = 22'h00_0000,
   parameter int               INIT_CLOCKS   = POWERUP_CLKS
) (
   input  wire logic              i_ref_clk,
   input  wire logic              i_rst_n,
   input  wire logic              i_cmd_line,
   input  wire logic              i_req_valid,
   input  wire logic [5:0]        i_req_index,
   input  wire logic [31:0]       i_req_arg,
   input  wire logic [SPEC_W-1:0] i_prog_image,
   input  wire logic              o_powerup_done,
   input  wire logic              o_resp_valid,
   input  wire logic              o_resp_refused,
   input  wire logic [SPEC_W-1:0] o_card_specific_data,
   input  wire logic [15:0]       o_relative_card_address,
   input  wire logic              o_write_blocked,
   input  wire logic              o_erase_go,
   input  wire logic [31:0]       o_erase_first,
   input  wire logic [31:0]       o_erase_last,
   input  wire logic              o_serial_bit,
   input  wire logic              o_serial_valid
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);
   logic [7:0] run_r;
   logic [7:0] run_nxt;
   logic       known;
   always_comb begin
      run_nxt = o_serial_valid ? run_r + 8'h01 : 8'h00;
      known   = i_req_index inside {CMD_SET_ADDRESS, CMD_SEND_SPECIFIC, CMD_PROGRAM_SPECIFIC,
                                    CMD_ERASE_START, CMD_ERASE_END, CMD_ERASE};
   end
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         run_r <= 8'h00;
      end else begin
         run_r <= run_nxt;
      end
   end
   sequence s_take_read;
      i_req_valid && o_powerup_done && i_req_index == CMD_SEND_SPECIFIC
         && !o_serial_valid && !o_resp_valid;
   endsequence
   sequence s_stream_head;
      o_resp_valid ##1 (o_serial_valid && o_serial_bit == o_card_specific_data[127]);
   endsequence
   a_answer_next: assert property (i_req_valid && o_powerup_done && known |=> o_resp_valid)
      else $error("no answer one cycle after a taken request");
   a_fixed_upper: assert property (o_card_specific_data[127:80] ==
      {2'h1, 6'h00, 8'h0E, 8'h00, 8'h32, 12'h5B5, 4'h9})
      else $error("upper fixed fields wrong");
   a_fixed_middle: assert property (o_card_specific_data[79:70] == 10'h000 &&
      o_card_specific_data[47:16] == {1'b0, 1'b1, 7'h7F, 7'h00, 1'b0, 2'h0, 3'h2, 4'h9, 6'h00})
      else $error("middle fixed fields wrong");
   a_fixed_low: assert property (!o_card_specific_data[15] &&
      o_card_specific_data[11:8] == 4'h0 && o_card_specific_data[0])
      else $error("low fixed fields wrong");
   a_capacity_field: assert property (o_card_specific_data[69:48] == CAPACITY_SIZE)
      else $error("capacity field differs from parameter");
   a_blocked_level: assert property (o_write_blocked ==
      (o_card_specific_data[TEMP_BIT] | o_card_specific_data[PERM_BIT]))
      else $error("write block level does not follow protect bits");
   a_erase_legal: assert property (o_erase_go |-> o_resp_valid && !o_resp_refused
      && o_erase_first != o_erase_last && !$past(o_write_blocked))
      else $error("erase started on a single block or while protected");
   a_stream_cap: assert property (run_r <= 8'h80)
      else $error("serial stream longer than the register");
   a_stream_len: assert property ($fell(o_serial_valid) |-> run_r == 8'h80)
      else $error("serial stream not exactly the register width");
   a_stream_start: assert property (s_take_read |=> s_stream_head)
      else $error("read does not start with the top bit");
endmodule
bind card_specific_data_and_powerup csd_properties #(.CAPACITY_SIZE(CAPACITY_SIZE),
   .INIT_CLOCKS(INIT_CLOCKS)) i_csd_properties (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
   .i_cmd_line(i_cmd_line), .i_req_valid(i_req_valid), .i_req_index(i_req_index),
   .i_req_arg(i_req_arg), .i_prog_image(i_prog_image), .o_powerup_done(o_powerup_done),
   .o_resp_valid(o_resp_valid), .o_resp_refused(o_resp_refused),
   .o_card_specific_data(o_card_specific_data),
   .o_relative_card_address(o_relative_card_address), .o_write_blocked(o_write_blocked),
   .o_erase_go(o_erase_go), .o_erase_first(o_erase_first), .o_erase_last(o_erase_last),
   .o_serial_bit(o_serial_bit), .o_serial_valid(o_serial_valid));
`default_nettype wire

/* dv/sd_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module sd_host_model (
   input  wire logic i_ref_clk,
   input  wire logic i_rst_n,
   input  wire logic i_hold_low,
   output var  logic o_cmd_line
);
   logic cmd_nxt;
   always_comb begin
      cmd_nxt = ~i_hold_low;
   end
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_cmd_line <= 1'b0;
      end else begin
         o_cmd_line <= cmd_nxt;
      end
   end
endmodule
`default_nettype wire

/* dv/tb_card_specific_data_and_powerup.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_card_specific_data_and_powerup;
   import spec_data_pkg::*;
   localparam logic [CAP_W-1:0] CAP = 22'h2A_5A5C;
   // supply held off for 1 ms at 100 ns per clock
   localparam int OFF_CLKS = 10000;
   logic clk = 1'b0, rst_n = 1'b0, hold_low = 1'b1, cmd_line, valid = 1'b0;
   logic [5:0] idx = 6'h00;
   logic [31:0] arg = 32'h0000_0000, first, last;
   logic [127:0] img = '0, csd, got;
   logic [15:0] relative_card_address;
   logic done, resp, refused, blocked, go, sbit, svalid;
   int failures = 0, checks = 0, cycles = 0;
   always #50 clk = ~clk;
   sd_host_model i_sd_host_model (.i_ref_clk(clk), .i_rst_n(rst_n), .i_hold_low(hold_low),
      .o_cmd_line(cmd_line));
   card_specific_data_and_powerup #(.CAPACITY_SIZE(CAP)) i_card_specific_data_and_powerup (
      .i_ref_clk(clk), .i_rst_n(rst_n), .i_cmd_line(cmd_line), .i_req_valid(valid),
      .i_req_index(idx), .i_req_arg(arg), .i_prog_image(img), .o_powerup_done(done),
      .o_resp_valid(resp), .o_resp_refused(refused), .o_card_specific_data(csd),
      .o_relative_card_address(relative_card_address), .o_write_blocked(blocked), .o_erase_go(go),
      .o_erase_first(first), .o_erase_last(last), .o_serial_bit(sbit),
      .o_serial_valid(svalid));
   task automatic check(input logic [127:0] seen, input logic [127:0] exp, input string msg);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask
   task automatic summarize();
      $display("failures=%0d checks=%0d", failures, checks);
      if (failures == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   function automatic logic [127:0] exp_img(input logic c, input logic p, input logic t,
                                             input logic [6:0] k);
      return {2'h1, 6'h00, 8'h0E, 8'h00, 8'h32, 12'h5B5, 4'h9, 4'h0, 6'h00, CAP, 1'b0, 1'b1,
              7'h7F, 7'h00, 1'b0, 2'h0, 3'h2, 4'h9, 1'b0, 5'h00, 1'b0, c, p, t, 4'h0, k, 1'b1};
   endfunction
   // request taken at one edge, answer sampled in the following cycle
   task automatic req(input logic [5:0] i, input logic [31:0] a, input logic [127:0] m);
      @(posedge clk);
      valid <= 1'b1;
      idx   <= i;
      arg   <= a;
      img   <= m;
      @(posedge clk);
      valid <= 1'b0;
      #1;
   endtask
   task automatic t_powerup();
      repeat (10) @(posedge clk);
      req(CMD_SET_ADDRESS, 32'hFFFF_0000, '0);
      check(resp, 1'b0, "request answered before power-up");
      hold_low <= 1'b1;
      @(posedge clk);
      hold_low <= 1'b0;
      repeat (74) @(posedge clk);
      #1 check(done, 1'b0, "power-up done too early");
      @(posedge clk);
      #1 check(done, 1'b1, "power-up never done");
      check(relative_card_address, 16'h0000, "early request had effect");
   endtask
   task automatic t_image();
      check(csd, exp_img(0, 0, 0, 7'h00), "reset image");
      check(blocked, 1'b0, "blocked after reset");
   endtask
   task automatic t_read();
      req(CMD_SEND_SPECIFIC, '0, '0);
      check(resp, 1'b1, "read not answered");
      idx <= CMD_SET_ADDRESS;
      arg <= 32'h7777_0000;
      for (int b = 127; b >= 0; b--) begin
         @(posedge clk);
         valid <= (b == 100);
         #1 got[b] = sbit;
         check(svalid, 1'b1, "serial valid dropped");
         if (b == 99) check({resp, refused}, 2'b11, "request during transfer");
      end
      check(got, exp_img(0, 0, 0, 7'h00), "serial image");
      check(relative_card_address, 16'h0000, "refused request had effect");
      @(posedge clk);
      #1 check(svalid, 1'b0, "serial valid too long");
   endtask
   task automatic t_erase();
      req(CMD_ERASE_START, 32'h0000_0005, '0);
      req(CMD_ERASE_END, 32'h0000_0005, '0);
      check(csd[46], 1'b1, "erase block enable not reported");
      req(CMD_ERASE, '0, '0);
      check({resp, refused, go}, 3'b110, "single block erase");
      req(CMD_ERASE_END, 32'h0000_0009, '0);
      req(CMD_ERASE, '0, '0);
      check({resp, refused, go}, 3'b101, "range erase");
      check({first, last}, {32'h0000_0005, 32'h0000_0009}, "erase range");
   endtask
   task automatic t_addr();
      req(CMD_SET_ADDRESS, 32'hABCD_0000, '0);
      check(relative_card_address, 16'hABCD, "address one");
      req(CMD_SET_ADDRESS, 32'h1234_FFFF, '0);
      check(relative_card_address, 16'h1234, "address two");
      req(6'h05, 32'hFFFF_0000, '0);
      check({resp, relative_card_address}, {1'b0, 16'h1234}, "unknown index");
   endtask
   task automatic t_prog();
      req(CMD_PROGRAM_SPECIFIC, '0, ~(128'h1 << PERM_BIT));
      check({resp, refused}, 2'b10, "first program");
      check(csd, exp_img(1, 0, 1, 7'h7F), "first program image");
      check(blocked, 1'b1, "temporary protect blocks");
      req(CMD_ERASE, '0, '0);
      check({resp, refused, go}, 3'b110, "erase while protected");
      req(CMD_PROGRAM_SPECIFIC, '0, 128'h0000_0000_0000_0000_0000_0000_0000_00AA);
      check({resp, refused}, 2'b11, "copy change refused");
      check(csd, exp_img(1, 0, 0, 7'h55), "second program image");
      check(blocked, 1'b0, "temporary protect cleared");
   endtask
   task automatic t_cycle();
      @(posedge clk);
      rst_n    <= 1'b0;
      hold_low <= 1'b1;
      repeat (OFF_CLKS) @(posedge clk);
      #1 check({done, resp, blocked, svalid}, 4'h0, "outputs during power off");
      check(csd, exp_img(0, 0, 0, 7'h00), "image during power off");
      check(relative_card_address, 16'h0000, "address during power off");
      @(posedge clk);
      rst_n    <= 1'b1;
      hold_low <= 1'b0;
      repeat (74) @(posedge clk);
      #1 check(done, 1'b0, "power-up early after cycle");
      @(posedge clk);
      #1 check(done, 1'b1, "power-up missing after cycle");
      req(CMD_PROGRAM_SPECIFIC, '0, 128'h1 << PERM_BIT);
      check({resp, refused}, 2'b10, "program after power cycle");
      check(csd, exp_img(0, 1, 0, 7'h00), "image after power cycle");
      check(blocked, 1'b1, "permanent protect blocks");
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 12000) begin
         failures++;
         summarize();
      end
   end
   initial begin
      repeat (20) @(posedge clk);
      rst_n    <= 1'b1;
      hold_low <= 1'b0;
      t_powerup();
      t_image();
      t_read();
      t_erase();
      t_addr();
      t_prog();
      t_cycle();
      summarize();
   end
endmodule
`default_nettype wire

/* rtl/card_specific_data_and_powerup.sv */
`timescale 1ns/10ps
`default_nettype none
module card_specific_data_and_powerup
   import spec_data_pkg::*;
#(
   parameter logic [CAP_W-1:0] CAPACITY_SIZE = 22'h00_0000,
   parameter int               INIT_CLOCKS   = POWERUP_CLKS
) (
   input  wire logic              i_ref_clk,
   input  wire logic              i_rst_n,
   input  wire logic              i_cmd_line,
   input  wire logic              i_req_valid,
   input  wire logic [5:0]        i_req_index,
   input  wire logic [31:0]       i_req_arg,
   input  wire logic [SPEC_W-1:0] i_prog_image,
   output var  logic              o_powerup_done,
   output var  logic              o_resp_valid,
   output var  logic              o_resp_refused,
   output var  logic [SPEC_W-1:0] o_card_specific_data,
   output var  logic [15:0]       o_relative_card_address,
   output var  logic              o_write_blocked,
   output var  logic              o_erase_go,
   output var  logic [31:0]       o_erase_first,
   output var  logic [31:0]       o_erase_last,
   output var  logic              o_serial_bit,
   output var  logic              o_serial_valid
);
   initial begin
      if (INIT_CLOCKS < POWERUP_CLKS) $error("power-up clocks below the minimum");
   end

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {ST_IDLE, ST_SENDING} send_state_t;

   send_state_t       state_r, state_nxt;
   logic              copy_r, copy_nxt;
   logic              perm_r, perm_nxt;
   logic              temp_r, temp_nxt;
   logic              otp_used_r, otp_used_nxt;
   logic [6:0]        check_r, check_nxt;
   logic [15:0]       addr_r, addr_nxt;
   logic [31:0]       first_r, first_nxt;
   logic [31:0]       last_r, last_nxt;
   logic              resp_r, resp_nxt;
   logic              refused_r, refused_nxt;
   logic              erase_go_r, erase_go_nxt;
   logic              load_r, load_nxt;
   logic [SPEC_W-1:0] image_r, image_nxt;
   logic              blocked_r, blocked_nxt;

   // image held while reset is asserted, built from constants only
   localparam logic [SPEC_W-1:0] IMAGE_RESET =
      build_image(CAPACITY_SIZE, 1'b0, 1'b0, 1'b0, CHECK_RESET);
   logic              powered;
   logic              take;

   serial_link_if #(.W(SPEC_W)) link ();

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   powerup_watch #(
      .CLOCKS (INIT_CLOCKS)
   ) u_powerup (
      .i_ref_clk  (i_ref_clk),
      .i_rst_n    (i_rst_n),
      .i_cmd_line (i_cmd_line),
      .o_done     (powered)
   );

   spec_shifter #(
      .W (SPEC_W)
   ) u_shifter (
      .i_ref_clk (i_ref_clk),
      .i_rst_n   (i_rst_n),
      .link      (link.shifter)
   );

   assign link.word = image_r;
   assign link.load = load_r;

   // ---------------------------------------------------------------
   // command handling
   // ---------------------------------------------------------------
   // nothing is taken before the power-up clocks have been seen
   assign take = i_req_valid && powered;

   always_comb begin
      state_nxt    = state_r;
      copy_nxt     = copy_r;
      perm_nxt     = perm_r;
      temp_nxt     = temp_r;
      otp_used_nxt = otp_used_r;
      check_nxt    = check_r;
      addr_nxt     = addr_r;
      first_nxt    = first_r;
      last_nxt     = last_r;
      resp_nxt     = 1'b0;
      refused_nxt  = 1'b0;
      erase_go_nxt = 1'b0;
      load_nxt     = 1'b0;
      case (state_r)
         ST_IDLE: begin
            if (take) begin
               case (i_req_index)
                  CMD_SEND_SPECIFIC: begin
                     resp_nxt  = 1'b1;
                     load_nxt  = 1'b1;
                     state_nxt = ST_SENDING;
                  end
                  CMD_PROGRAM_SPECIFIC: begin
                     // read-only fields of the image are simply dropped
                     resp_nxt  = 1'b1;
                     temp_nxt  = i_prog_image[TEMP_BIT];
                     check_nxt = i_prog_image[CHECK_LO +: 7];
                     if (!otp_used_r) begin
                        copy_nxt     = i_prog_image[COPY_BIT];
                        perm_nxt     = i_prog_image[PERM_BIT];
                        otp_used_nxt = 1'b1;
                     end else if (i_prog_image[COPY_BIT] != copy_r ||
                                  i_prog_image[PERM_BIT] != perm_r) begin
                        refused_nxt = 1'b1;
                     end
                  end
                  CMD_SET_ADDRESS: begin
                     resp_nxt = 1'b1;
                     addr_nxt = i_req_arg[31:16];
                  end
                  CMD_ERASE_START: begin
                     resp_nxt  = 1'b1;
                     first_nxt = i_req_arg;
                  end
                  CMD_ERASE_END: begin
                     resp_nxt = 1'b1;
                     last_nxt = i_req_arg;
                  end
                  CMD_ERASE: begin
                     resp_nxt = 1'b1;
                     if (first_r == last_r || temp_r || perm_r) begin
                        refused_nxt = 1'b1;
                     end else begin
                        erase_go_nxt = 1'b1;
                     end
                  end
                  default: begin
                  end
               endcase
            end
         end
         ST_SENDING: begin
            // every request during the transfer is answered as refused
            if (take) begin
               resp_nxt    = 1'b1;
               refused_nxt = 1'b1;
            end
            if (!load_r && !link.busy) begin
               state_nxt = ST_IDLE;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
      image_nxt = build_image(CAPACITY_SIZE, copy_nxt, perm_nxt,
                              temp_nxt, check_nxt);
      blocked_nxt = temp_nxt | perm_nxt;
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_r    <= ST_IDLE;
         copy_r     <= 1'b0;
         perm_r     <= 1'b0;
         temp_r     <= 1'b0;
         otp_used_r <= 1'b0;
         check_r    <= CHECK_RESET;
         addr_r     <= ADDRESS_RESET;
         first_r    <= '0;
         last_r     <= '0;
         resp_r     <= 1'b0;
         refused_r  <= 1'b0;
         erase_go_r <= 1'b0;
         load_r     <= 1'b0;
         image_r    <= IMAGE_RESET;
         blocked_r  <= 1'b0;
      end else begin
         state_r    <= state_nxt;
         copy_r     <= copy_nxt;
         perm_r     <= perm_nxt;
         temp_r     <= temp_nxt;
         otp_used_r <= otp_used_nxt;
         check_r    <= check_nxt;
         addr_r     <= addr_nxt;
         first_r    <= first_nxt;
         last_r     <= last_nxt;
         resp_r     <= resp_nxt;
         refused_r  <= refused_nxt;
         erase_go_r <= erase_go_nxt;
         load_r     <= load_nxt;
         image_r    <= image_nxt;
         blocked_r  <= blocked_nxt;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign o_powerup_done          = powered;
   assign o_resp_valid            = resp_r;
   assign o_resp_refused          = refused_r;
   assign o_card_specific_data    = image_r;
   assign o_relative_card_address = addr_r;
   assign o_write_blocked         = blocked_r;
   assign o_erase_go              = erase_go_r;
   assign o_erase_first           = first_r;
   assign o_erase_last            = last_r;
   assign o_serial_bit            = link.bit_out;
   assign o_serial_valid          = link.bit_valid;
endmodule
`default_nettype wire

/* rtl/powerup_watch.sv */
`timescale 1ns/10ps
`default_nettype none
module powerup_watch #(
   parameter int CLOCKS = 74
) (
   input  wire logic i_ref_clk,
   input  wire logic i_rst_n,
   input  wire logic i_cmd_line,
   output var  logic o_done
);
   localparam int CW = $clog2(CLOCKS + 1);
   logic [CW-1:0] cnt_r, cnt_nxt;
   logic          done_r, done_nxt;

   initial begin
      if (CLOCKS < 1) $error("power-up clock count must be at least one");
   end

   // a low command line before the count completes restarts the count
   always_comb begin
      cnt_nxt  = cnt_r;
      done_nxt = done_r;
      if (!done_r) begin
         if (!i_cmd_line) begin
            cnt_nxt = '0;
         end else if (cnt_r == CW'(CLOCKS - 1)) begin
            done_nxt = 1'b1;
         end else begin
            cnt_nxt = cnt_r + 1'b1;
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_r  <= '0;
         done_r <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         done_r <= done_nxt;
      end
   end

   assign o_done = done_r;
endmodule
`default_nettype wire

/* rtl/serial_link_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface serial_link_if #(parameter int W = 128);
   logic         load;
   logic [W-1:0] word;
   logic         busy;
   logic         bit_out;
   logic         bit_valid;
   modport source  (output load, output word, input busy, input bit_out, input bit_valid);
   modport shifter (input load, input word, output busy, output bit_out, output bit_valid);
endinterface
`default_nettype wire

/* rtl/spec_data_pkg.sv */
`default_nettype none
package spec_data_pkg;
   localparam int          SPEC_W        = 128;
   localparam int          CAP_W         = 22;
   localparam int          POWERUP_CLKS  = 74;
   // ---------------------------------------------------------------
   // command indices
   // ---------------------------------------------------------------
   localparam logic [5:0]  CMD_SET_ADDRESS      = 6'h03;
   localparam logic [5:0]  CMD_SEND_SPECIFIC    = 6'h09;
   localparam logic [5:0]  CMD_PROGRAM_SPECIFIC = 6'h1B;
   localparam logic [5:0]  CMD_ERASE_START      = 6'h20;
   localparam logic [5:0]  CMD_ERASE_END        = 6'h21;
   localparam logic [5:0]  CMD_ERASE            = 6'h26;
   // ---------------------------------------------------------------
   // field positions and fixed values
   // ---------------------------------------------------------------
   localparam logic [1:0]  STRUCTURE_VERSION_VAL = 2'h1;
   localparam logic [7:0]  READ_ACCESS_TIME_VAL  = 8'h0E;
   localparam logic [7:0]  CLOCK_ACCESS_VAL      = 8'h00;
   localparam logic [7:0]  TRANSFER_RATE_VAL     = 8'h32;
   localparam logic [11:0] COMMAND_CLASS_VAL     = 12'h5B5;
   localparam logic [3:0]  READ_BLOCK_LEN_VAL    = 4'h9;
   localparam logic        ERASE_BLOCK_EN_VAL    = 1'b1;
   localparam logic [6:0]  SECTOR_SIZE_VAL       = 7'h7F;
   localparam logic [6:0]  PROTECT_GRP_SIZE_VAL  = 7'h00;
   localparam logic [2:0]  READ_TO_WRITE_VAL     = 3'h2;
   localparam logic [3:0]  WRITE_BLOCK_LEN_VAL   = 4'h9;
   localparam logic [1:0]  CODE_A_VAL            = 2'h0;
   localparam int          CAP_LO       = 48;
   localparam int          COPY_BIT     = 14;
   localparam int          PERM_BIT     = 13;
   localparam int          TEMP_BIT     = 12;
   localparam int          CHECK_LO     = 1;
   localparam logic [6:0]  CHECK_RESET  = 7'h00;
   localparam logic [15:0] ADDRESS_RESET = 16'h0000;

   function automatic logic [SPEC_W-1:0] build_image(
      input logic [CAP_W-1:0] cap,
      input logic             copy_f,
      input logic             perm_f,
      input logic             temp_f,
      input logic [6:0]       check);
      logic [SPEC_W-1:0] img;
      img            = '0;
      img[127:126]   = STRUCTURE_VERSION_VAL;
      img[119:112]   = READ_ACCESS_TIME_VAL;
      img[111:104]   = CLOCK_ACCESS_VAL;
      img[103:96]    = TRANSFER_RATE_VAL;
      img[95:84]     = COMMAND_CLASS_VAL;
      img[83:80]     = READ_BLOCK_LEN_VAL;
      img[79:76]     = 4'h0;
      img[69:48]     = cap;
      img[46]        = ERASE_BLOCK_EN_VAL;
      img[45:39]     = SECTOR_SIZE_VAL;
      img[38:32]     = PROTECT_GRP_SIZE_VAL;
      img[31]        = 1'b0;
      img[28:26]     = READ_TO_WRITE_VAL;
      img[25:22]     = WRITE_BLOCK_LEN_VAL;
      img[21]        = 1'b0;
      img[15]        = 1'b0;
      img[COPY_BIT]  = copy_f;
      img[PERM_BIT]  = perm_f;
      img[TEMP_BIT]  = temp_f;
      img[11:10]     = CODE_A_VAL;
      img[7:1]       = check;
      img[0]         = 1'b1;
      return img;
   endfunction
endpackage
`default_nettype wire

/* rtl/spec_shifter.sv */
`timescale 1ns/10ps
`default_nettype none
module spec_shifter #(
   parameter int W = 128
) (
   input  wire logic          i_ref_clk,
   input  wire logic          i_rst_n,
   serial_link_if.shifter     link
);
   localparam int CW = $clog2(W) + 1;
   logic [W-1:0]  shreg_r, shreg_nxt;
   logic [CW-1:0] cnt_r, cnt_nxt;
   logic          bit_r, bit_nxt;
   logic          valid_r, valid_nxt;

   initial begin
      if (W < 2) $error("shifter width too small");
   end

   always_comb begin
      shreg_nxt = shreg_r;
      cnt_nxt   = cnt_r;
      bit_nxt   = bit_r;
      valid_nxt = 1'b0;
      if (link.load && !valid_r) begin
         bit_nxt   = link.word[W-1];
         shreg_nxt = {link.word[W-2:0], 1'b0};
         cnt_nxt   = CW'(W - 1);
         valid_nxt = 1'b1;
      end else if (cnt_r != '0) begin
         bit_nxt   = shreg_r[W-1];
         shreg_nxt = {shreg_r[W-2:0], 1'b0};
         cnt_nxt   = cnt_r - 1'b1;
         valid_nxt = 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         shreg_r <= '0;
         cnt_r   <= '0;
         bit_r   <= 1'b0;
         valid_r <= 1'b0;
      end else begin
         shreg_r <= shreg_nxt;
         cnt_r   <= cnt_nxt;
         bit_r   <= bit_nxt;
         valid_r <= valid_nxt;
      end
   end

   assign link.busy      = valid_r;
   assign link.bit_out   = bit_r;
   assign link.bit_valid = valid_r;
endmodule
`default_nettype wire
